// File: rtl/dss_cfg.svh
// register map, field positions, reset values and timing figures of the start/stop sequencer
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH

`define DSS_CLK_MHZ 20
`define DSS_STEP_NS 1000
`define DSS_TICK_US 1000

`define DSS_LOCK_MS 16'h0064
`define DSS_LOAD_MS 16'h07d0
`define DSS_ROT_MS 16'h0064

`define DSS_OFS_CTRL 4'h0
`define DSS_OFS_PURGE 4'h4
`define DSS_OFS_STATUS 4'h8

`define DSS_CTRL_EMERG_BIT 0
`define DSS_CTRL_RST 1'h0
`define DSS_PURGE_RST 16'h7530

`define DSS_ST_ROT_BIT 4
`define DSS_ST_READY_BIT 5
`define DSS_ST_EMERG_BIT 6
`define DSS_ST_LOAD_BIT 7
`define DSS_ST_PURGE_BIT 8
`define DSS_ST_LOCK_BIT 9

`endif

// File: rtl/dss_pkg.sv
// types shared by the start/stop sequencer
package dss_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOCK, ST_MSTART, ST_SPINUP, ST_PURGE, ST_LOAD, ST_READY, ST_UNLOAD, ST_BRAKE, ST_EMERG
  } dss_state_t;

  typedef struct packed {
    logic brake_enable_n;
    logic cartridge_lock;
    logic emergency_relay_enable;
  } dss_servo_t;

  typedef struct packed {
    logic safe_lamp_n;
    logic run_lamp_n;
    logic ready_lamp_n;
  } dss_lamps_t;

endpackage

// File: rtl/dss_sequencer.sv
// start/stop sequencer of a cartridge disk drive with an avalon-mm register slave
`timescale 1ns/1ns
`include "dss_cfg.svh"

// What this block does
// - run/stop comes from the operator switch or the host start/stop line.
// - state flip-flops change only on gated step pulses, otherwise hold.
// - delays are counted in ticks of the crystal countdown chain.
// - rotation pulses prove spinning; cartridge stays locked while spinning.
// - normal unload waits while a write or erase is active.
// - no start without a cartridge present.
// - spindle may not stop before heads are retracted.
// - external emergency, transducer failure or write emergency start emergency unload.
// - heads failing to reach position mode during start cause emergency unload.
// - heads load only once the disk speed is in tolerance.
// - travel limit error causes emergency unload.
// - disk speed error after ready causes emergency unload.
// - seek timeout error causes emergency unload.
// - one motor start pulse at the start of a start sequence.
// - purge state flip-flop marks the whole purge cycle.
// - head load flip-flop drives head loading and unloading.
// - emergency flip-flop set at emergency start, held while cause persists.
// - load-or-purge-not decodes purge and head load flip-flops.
// - drive brake enable, cartridge lock and emergency relay enable.
// - drive safe, run and ready lamps.
// - ready formed from state; selected-and-ready is ready and unit select.
// - with interrupt option, file ready, ready to seek and seek incomplete are not gated by unit select.
module dss_sequencer #(
  parameter int TICK_CYC = `DSS_TICK_US * `DSS_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic operator_run_switch,
  input wire logic host_start_stop_line,
  input wire logic cartridge_present,
  input wire logic rotation_sense_pulse,
  input wire logic write_or_erase_active_n,
  input wire logic power_fault_clear,
  input wire logic heads_retracted,
  input wire logic transducer_failure,
  input wire logic write_emergency,
  input wire logic not_position_mode,
  input wire logic speed_out_of_tolerance,
  input wire logic travel_limit_error_n,
  input wire logic disk_speed_error_n,
  input wire logic seek_timeout_error_n,
  input wire logic unit_selected,
  input wire logic interrupt_option,
  input wire logic seek_complete_in,
  input wire logic seek_incomplete_in,
  output logic motor_start_pulse_n,
  output logic purge_cycle_state,
  output logic head_load_state,
  output logic emergency_unload_state,
  output logic load_or_purge_n,
  output logic spindle_enable,
  output dss_pkg::dss_servo_t servo_out,
  output dss_pkg::dss_lamps_t lamps_out,
  output logic drive_ready,
  output logic selected_and_ready,
  output logic delayed_ready,
  output logic file_ready,
  output logic ready_to_seek_rw,
  output logic seek_incomplete
);

  localparam int STEP_CYC = (`DSS_STEP_NS * `DSS_CLK_MHZ) / 1000;

  if (TICK_CYC < STEP_CYC || STEP_CYC < 2) begin : g_bad_timing
    $error("tick must be at least one step and a step at least two clocks");
  end

  function automatic logic [15:0] dss_dec(input logic [15:0] v);
    dss_dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction

  // ==========================================================
  // clock countdown
  logic [15:0] step_cnt_q;
  logic [31:0] tick_cnt_q;
  logic step_q;
  logic tick_q;

  // the countdown free runs; only the pulses it makes gate the state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      step_cnt_q <= 16'h0000;
      step_q <= 1'b0;
    end else if (step_cnt_q == 16'(STEP_CYC - 1)) begin
      step_cnt_q <= 16'h0000;
      step_q <= 1'b1;
    end else begin
      step_cnt_q <= step_cnt_q + 16'h0001;
      step_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // register slave
  logic soft_emerg_q;
  logic [15:0] purge_ms_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] status_w;
  dss_pkg::dss_state_t state_q;
  dss_pkg::dss_state_t state_d;
  logic head_load_q;
  logic purge_q;
  logic emerg_q;
  logic rotating_q;
  logic ready_w;
  logic lock_w;
  logic bus_req;
  logic bus_take;

  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & !wait_q;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[3:0] = state_q;
    status_w[`DSS_ST_ROT_BIT] = rotating_q;
    status_w[`DSS_ST_READY_BIT] = ready_w;
    status_w[`DSS_ST_EMERG_BIT] = emerg_q;
    status_w[`DSS_ST_LOAD_BIT] = head_load_q;
    status_w[`DSS_ST_PURGE_BIT] = purge_q;
    status_w[`DSS_ST_LOCK_BIT] = lock_w;
  end

  // one wait cycle per access: waitrequest drops the cycle after the request rises
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !(bus_req & wait_q);
      if (avs_read & wait_q) begin
        if (avs_address[3:2] == `DSS_OFS_CTRL >> 2) begin
          rdata_q <= {31'h0000_0000, soft_emerg_q};
        end else if (avs_address[3:2] == `DSS_OFS_PURGE >> 2) begin
          rdata_q <= {16'h0000, purge_ms_q};
        end else if (avs_address[3:2] == `DSS_OFS_STATUS >> 2) begin
          rdata_q <= status_w;
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      soft_emerg_q <= `DSS_CTRL_RST;
      purge_ms_q <= `DSS_PURGE_RST;
    end else if (bus_take & avs_write) begin
      if (avs_address[3:2] == `DSS_OFS_CTRL >> 2) begin
        if (avs_byteenable[0]) soft_emerg_q <= avs_writedata[`DSS_CTRL_EMERG_BIT];
      end else if (avs_address[3:2] == `DSS_OFS_PURGE >> 2) begin
        if (avs_byteenable[0]) purge_ms_q[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) purge_ms_q[15:8] <= avs_writedata[15:8];
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ==========================================================
  // rotation detect
  logic [15:0] rot_cnt_q;

  // retriggered by every sense pulse; lapses after a quiet spell
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rot_cnt_q <= 16'h0000;
      rotating_q <= 1'b0;
    end else if (rotation_sense_pulse) begin
      rot_cnt_q <= `DSS_ROT_MS;
      rotating_q <= 1'b1;
    end else if (tick_q) begin
      rot_cnt_q <= dss_dec(rot_cnt_q);
      rotating_q <= (rot_cnt_q > 16'h0001);
    end
  end

  // ==========================================================
  // sequencer
  logic run_req;
  logic fault_any;
  logic dly_done;
  logic dly_load;
  logic [15:0] dly_val;
  logic [15:0] dly_q;
  logic pos_fail;

  assign run_req = operator_run_switch | host_start_stop_line;
  assign ready_w = (state_q == dss_pkg::ST_READY) & head_load_q & !emerg_q & !not_position_mode;
  assign dly_done = (dly_q == 16'h0000);
  assign pos_fail = (state_q == dss_pkg::ST_LOAD) & not_position_mode & dly_done;
  assign fault_any = soft_emerg_q | transducer_failure | write_emergency
    | !travel_limit_error_n
    | !seek_timeout_error_n
    | (ready_w & !disk_speed_error_n)
    | power_fault_clear;

  always_comb begin
    state_d = state_q;
    dly_load = 1'b0;
    dly_val = 16'h0000;
    if ((fault_any | pos_fail) && state_q != dss_pkg::ST_IDLE && state_q != dss_pkg::ST_BRAKE) begin
      state_d = dss_pkg::ST_EMERG;
    end else begin
      case (state_q)
        dss_pkg::ST_IDLE: begin
          if (run_req && cartridge_present && !power_fault_clear && !fault_any) begin
            state_d = dss_pkg::ST_LOCK;
            dly_load = 1'b1;
            dly_val = `DSS_LOCK_MS;
          end
        end
        dss_pkg::ST_LOCK: begin
          if (!run_req) state_d = dss_pkg::ST_UNLOAD;
          else if (dly_done) state_d = dss_pkg::ST_MSTART;
        end
        dss_pkg::ST_MSTART: begin
          state_d = dss_pkg::ST_SPINUP;
        end
        dss_pkg::ST_SPINUP: begin
          if (!run_req) begin
            state_d = dss_pkg::ST_UNLOAD;
          end else if (!speed_out_of_tolerance) begin
            state_d = dss_pkg::ST_PURGE;
            dly_load = 1'b1;
            dly_val = purge_ms_q;
          end
        end
        dss_pkg::ST_PURGE: begin
          if (!run_req) begin
            state_d = dss_pkg::ST_UNLOAD;
          end else if (dly_done && !speed_out_of_tolerance) begin
            state_d = dss_pkg::ST_LOAD;
            dly_load = 1'b1;
            dly_val = `DSS_LOAD_MS;
          end
        end
        dss_pkg::ST_LOAD: begin
          if (!not_position_mode) state_d = dss_pkg::ST_READY;
          else if (!run_req) state_d = dss_pkg::ST_UNLOAD;
        end
        dss_pkg::ST_READY: begin
          if (!run_req) state_d = dss_pkg::ST_UNLOAD;
        end
        dss_pkg::ST_UNLOAD, dss_pkg::ST_EMERG: begin
          if (heads_retracted && !head_load_q) state_d = dss_pkg::ST_BRAKE;
        end
        dss_pkg::ST_BRAKE: begin
          if (!rotating_q) state_d = dss_pkg::ST_IDLE;
        end
        default: state_d = dss_pkg::ST_IDLE;
      endcase
    end
  end

  // every state flop below except the delay counter moves only on a step pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= dss_pkg::ST_IDLE;
    end else if (step_q) begin
      state_q <= state_d;
    end
  end

  // delay counter runs on the countdown tick, loaded by the sequencer's decode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dly_q <= 16'h0000;
    end else if (step_q && dly_load) begin
      dly_q <= dly_val;
    end else if (tick_q) begin
      dly_q <= dss_dec(dly_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      purge_q <= 1'b0;
    end else if (step_q) begin
      purge_q <= (state_d == dss_pkg::ST_PURGE);
    end
  end

  // a normal unload holds the heads down until the write or erase ends
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      head_load_q <= 1'b0;
    end else if (step_q) begin
      if (state_d == dss_pkg::ST_EMERG) begin
        head_load_q <= 1'b0;
      end else if (state_d == dss_pkg::ST_LOAD) begin
        head_load_q <= 1'b1;
      end else if (state_d == dss_pkg::ST_UNLOAD && write_or_erase_active_n) begin
        head_load_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      emerg_q <= 1'b0;
    end else if (step_q) begin
      if (state_d == dss_pkg::ST_EMERG) begin
        emerg_q <= 1'b1;
      end else if (state_q == dss_pkg::ST_IDLE && !fault_any) begin
        emerg_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outputs, all registered one clock behind the state except delayed ready, which follows one step behind
  assign lock_w = (state_q != dss_pkg::ST_IDLE) | rotating_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      motor_start_pulse_n <= 1'b1;
      purge_cycle_state <= 1'b0;
      head_load_state <= 1'b0;
      emergency_unload_state <= 1'b0;
      load_or_purge_n <= 1'b1;
      spindle_enable <= 1'b0;
    end else begin
      motor_start_pulse_n <= !(step_q && state_q == dss_pkg::ST_MSTART);
      purge_cycle_state <= purge_q;
      head_load_state <= head_load_q;
      emergency_unload_state <= emerg_q;
      load_or_purge_n <= !(purge_q | head_load_q);
      spindle_enable <= state_q inside {dss_pkg::ST_MSTART, dss_pkg::ST_SPINUP, dss_pkg::ST_PURGE,
        dss_pkg::ST_LOAD, dss_pkg::ST_READY, dss_pkg::ST_UNLOAD, dss_pkg::ST_EMERG};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      servo_out <= '{brake_enable_n: 1'b1, cartridge_lock: 1'b0, emergency_relay_enable: 1'b0};
      lamps_out <= '{safe_lamp_n: 1'b0, run_lamp_n: 1'b1, ready_lamp_n: 1'b1};
    end else begin
      servo_out.brake_enable_n <= !(state_q == dss_pkg::ST_BRAKE);
      servo_out.cartridge_lock <= lock_w;
      servo_out.emergency_relay_enable <= emerg_q & !heads_retracted;
      lamps_out.safe_lamp_n <= lock_w;
      lamps_out.run_lamp_n <= !((state_q != dss_pkg::ST_IDLE && state_q != dss_pkg::ST_BRAKE) | rotating_q);
      lamps_out.ready_lamp_n <= !ready_w;
    end
  end

  // without the option the attention lines only speak for the selected unit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_ready <= 1'b0;
      selected_and_ready <= 1'b0;
      delayed_ready <= 1'b0;
      file_ready <= 1'b0;
      ready_to_seek_rw <= 1'b0;
      seek_incomplete <= 1'b0;
    end else begin
      drive_ready <= ready_w;
      selected_and_ready <= ready_w & unit_selected;
      if (step_q) delayed_ready <= ready_w;
      file_ready <= ready_w & (interrupt_option | unit_selected);
      ready_to_seek_rw <= ready_w & seek_complete_in & (interrupt_option | unit_selected);
      seek_incomplete <= ready_w & seek_incomplete_in & (interrupt_option | unit_selected);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_ask;
    bus_req && wait_q;
  endsequence

  sequence s_bus_ans;
    !wait_q ##1 wait_q;
  endsequence

  AST_BUS_ONE_WAIT: assert property (s_bus_ask |=> s_bus_ans) else $error("bus answer not after one wait");
  AST_STATE_GATED: assert property (!step_q |=> $stable(state_q)) else $error("state moved without step");
  AST_NO_CART_NO_START: assert property (state_q == dss_pkg::ST_IDLE && !cartridge_present |=>
    state_q == dss_pkg::ST_IDLE) else $error("start without cartridge");
  AST_LOCK_WHILE_SPIN: assert property (rotating_q |=> servo_out.cartridge_lock)
    else $error("cartridge unlocked while rotating");
  AST_WRITE_HOLDS_HEADS: assert property (state_q == dss_pkg::ST_UNLOAD && head_load_q && !write_or_erase_active_n
    |=> head_load_q) else $error("heads retracted during write");
  AST_BRAKE_AFTER_RETRACT: assert property ($changed(state_q) && state_q == dss_pkg::ST_BRAKE |->
    $past(heads_retracted)) else $error("brake before heads retracted");
  AST_FAULT_EMERG: assert property (step_q && transducer_failure && !(state_q inside {dss_pkg::ST_IDLE, dss_pkg::ST_BRAKE})
    |=> emerg_q && state_q == dss_pkg::ST_EMERG) else $error("fault did not start emergency");
  AST_LOAD_IN_SPEED: assert property ($rose(head_load_q) |-> !$past(speed_out_of_tolerance))
    else $error("heads loaded out of speed");
  AST_MSTART_SINGLE: assert property (!motor_start_pulse_n |=> motor_start_pulse_n [*8])
    else $error("motor start pulse too long");
  AST_LOP_DECODE: assert property ((purge_q || head_load_q) |=> !load_or_purge_n)
    else $error("load or purge decode wrong");
  AST_SEL_READY: assert property (selected_and_ready |-> drive_ready)
    else $error("selected ready without ready");

endmodule // dss_sequencer

// File: tb/disk_start_stop_sequencer_tb.sv
// self-checking bench for the start/stop sequencer
`timescale 1ns/1ns
`include "dss_cfg.svh"

module disk_start_stop_sequencer_tb;
  localparam int TICK = 40;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic operator_run_switch, host_start_stop_line, cartridge_present, rotation_sense_pulse;
  logic write_or_erase_active_n, power_fault_clear, heads_retracted, transducer_failure, write_emergency;
  logic not_position_mode, speed_out_of_tolerance, travel_limit_error_n, disk_speed_error_n;
  logic seek_timeout_error_n, unit_selected, interrupt_option, seek_complete_in, seek_incomplete_in;
  logic motor_start_pulse_n, purge_cycle_state, head_load_state, emergency_unload_state, load_or_purge_n;
  logic spindle_enable, drive_ready, selected_and_ready, delayed_ready, file_ready, ready_to_seek_rw;
  logic seek_incomplete;
  logic hl_q = 1'b0;
  logic se_q = 1'b0;
  logic lk_q = 1'b0;
  dss_pkg::dss_servo_t servo_out;
  dss_pkg::dss_lamps_t lamps_out;
  int n_fail = 0;
  int n_compared = 0;
  int n_mpulse = 0;
  int since_rot = 0;

  dss_sequencer #(.TICK_CYC(TICK)) dss_sequencer_i (
    .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .operator_run_switch, .host_start_stop_line, .cartridge_present,
    .rotation_sense_pulse, .write_or_erase_active_n, .power_fault_clear, .heads_retracted,
    .transducer_failure, .write_emergency, .not_position_mode, .speed_out_of_tolerance,
    .travel_limit_error_n, .disk_speed_error_n, .seek_timeout_error_n, .unit_selected, .interrupt_option,
    .seek_complete_in, .seek_incomplete_in, .motor_start_pulse_n, .purge_cycle_state, .head_load_state,
    .emergency_unload_state, .load_or_purge_n, .spindle_enable, .servo_out, .lamps_out, .drive_ready,
    .selected_and_ready, .delayed_ready, .file_ready, .ready_to_seek_rw, .seek_incomplete
  );

  dss_servo_model #(.TICK(TICK)) dss_servo_model_i (
    .sys_clk, .rst_n, .spindle_enable, .head_load_state, .rotation_sense_pulse, .speed_out_of_tolerance,
    .not_position_mode, .heads_retracted
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // the request stands until the edge that samples waitrequest low; read data is taken at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) chk("bus answer", 32'h0, 32'h1);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0, d);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask

  task automatic wait_st(input logic [3:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(`DSS_OFS_STATUS);
      if (d[3:0] === s) break;
      repeat (16) @(posedge sys_clk);
    end
    chk("state", {28'h0, s}, {28'h0, d[3:0]});
  endtask

  task automatic fault(input int i, input logic on);
    case (i)
      0: transducer_failure <= on;
      1: write_emergency <= on;
      2: travel_limit_error_n <= !on;
      3: seek_timeout_error_n <= !on;
      4: wr(`DSS_OFS_CTRL, {31'h0, on});
      default: power_fault_clear <= on;
    endcase
  endtask

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // monitors on the pins, sampled mid-cycle
  always @(negedge sys_clk) begin
    since_rot <= (rotation_sense_pulse === 1'b1) ? 0 : since_rot + 1;
    if (motor_start_pulse_n === 1'b0) n_mpulse <= n_mpulse + 1;
    if (head_load_state === 1'b1 && hl_q === 1'b0) chk("speed at load", 32'h0, speed_out_of_tolerance);
    if (spindle_enable === 1'b0 && se_q === 1'b1) chk("retracted at stop", 32'h1, heads_retracted);
    if (servo_out.cartridge_lock === 1'b0 && lk_q === 1'b1) chk("rotation lapsed", 32'h1, since_rot >= 90 * TICK);
    hl_q <= head_load_state;
    se_q <= spindle_enable;
    lk_q <= servo_out.cartridge_lock;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    {avs_read, avs_write, operator_run_switch, host_start_stop_line, power_fault_clear} = '0;
    {transducer_failure, write_emergency, interrupt_option, seek_complete_in, seek_incomplete_in} = '0;
    {cartridge_present, write_or_erase_active_n, travel_limit_error_n, disk_speed_error_n} = '1;
    {seek_timeout_error_n, unit_selected} = 2'h3;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("lamps", 32'h3, lamps_out);
    chk("servo", 32'h4, servo_out);
    chk("motor start", 32'h1, motor_start_pulse_n);
    chk("load or purge", 32'h1, load_or_purge_n);
    rd(`DSS_OFS_CTRL);
    chk("ctrl", 32'h0, d);
    rd(`DSS_OFS_PURGE);
    chk("purge", `DSS_PURGE_RST, d);
    rd(4'hc);
    chk("unmapped", 32'h0, d);
    cartridge_present <= 1'b0;
    operator_run_switch <= 1'b1;
    repeat (200) @(posedge sys_clk);
    wait_st(dss_pkg::ST_IDLE, 1);
    cartridge_present <= 1'b1;
    power_fault_clear <= 1'b1;
    repeat (200) @(posedge sys_clk);
    wait_st(dss_pkg::ST_IDLE, 1);
    operator_run_switch <= 1'b0;
    power_fault_clear <= 1'b0;
    // a short purge keeps the run length sane
    wr(`DSS_OFS_PURGE, 32'ha);
    rd(`DSS_OFS_PURGE);
    chk("purge", 32'ha, d);
    host_start_stop_line <= 1'b1;
    wait_st(dss_pkg::ST_LOCK, 20);
    chk("lock", 32'h1, servo_out.cartridge_lock);
    wait_st(dss_pkg::ST_PURGE, 600);
    chk("purge state", 32'h1, purge_cycle_state);
    chk("load or purge", 32'h0, load_or_purge_n);
    chk("ready early", 32'h0, drive_ready);
    wait_st(dss_pkg::ST_READY, 100);
    chk("motor pulses", 32'h1, n_mpulse);
    chk("head load", 32'h1, head_load_state);
    chk("ready", 32'h1, drive_ready);
    chk("lamps", 32'h4, lamps_out);
    chk("sel ready", 32'h1, selected_and_ready);
    unit_selected <= 1'b0;
    interrupt_option <= 1'b1;
    seek_incomplete_in <= 1'b1;
    seek_complete_in <= 1'b1;
    repeat (45) @(posedge sys_clk);
    chk("sel ready", 32'h0, selected_and_ready);
    chk("ready to seek", 32'h1, ready_to_seek_rw);
    chk("file ready", 32'h1, file_ready);
    chk("seek incomplete", 32'h1, seek_incomplete);
    chk("delayed ready", 32'h1, delayed_ready);
    unit_selected <= 1'b1;
    interrupt_option <= 1'b0;
    seek_incomplete_in <= 1'b0;
    disk_speed_error_n <= 1'b0;
    repeat (45) @(posedge sys_clk);
    chk("emergency", 32'h1, emergency_unload_state);
    chk("relay", 32'h1, servo_out.emergency_relay_enable);
    chk("head load", 32'h0, head_load_state);
    disk_speed_error_n <= 1'b1;
    host_start_stop_line <= 1'b0;
    wait_st(dss_pkg::ST_BRAKE, 600);
    chk("brake", 32'h0, servo_out.brake_enable_n);
    wait_st(dss_pkg::ST_IDLE, 600);
    // the emergency flop only clears on a step taken in idle
    repeat (45) @(posedge sys_clk);
    chk("emergency", 32'h0, emergency_unload_state);
    chk("lamps", 32'h3, lamps_out);
    operator_run_switch <= 1'b1;
    wait_st(dss_pkg::ST_READY, 600);
    chk("motor pulses", 32'h2, n_mpulse);
    write_or_erase_active_n <= 1'b0;
    operator_run_switch <= 1'b0;
    wait_st(dss_pkg::ST_UNLOAD, 10);
    repeat (400) @(posedge sys_clk);
    chk("head load", 32'h1, head_load_state);
    write_or_erase_active_n <= 1'b1;
    wait_st(dss_pkg::ST_IDLE, 600);
    for (int i = 0; i < 6; i++) begin
      host_start_stop_line <= 1'b1;
      wait_st(dss_pkg::ST_LOCK, 20);
      fault(i, 1'b1);
      repeat (45) @(posedge sys_clk);
      chk("emergency", 32'h1, emergency_unload_state);
      fault(i, 1'b0);
      host_start_stop_line <= 1'b0;
      wait_st(dss_pkg::ST_IDLE, 600);
    end
    end_of_test();
  end
endmodule // disk_start_stop_sequencer_tb

// File: tb/dss_servo_model.sv
// behavioural model of the spindle, rotation sensor and head positioner facing the sequencer
`timescale 1ns/1ns

module dss_servo_model #(
  parameter int TICK = 40
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spindle_enable,
  input wire logic head_load_state,
  output logic rotation_sense_pulse,
  output logic speed_out_of_tolerance,
  output logic not_position_mode,
  output logic heads_retracted
);
  localparam int SPIN = 30 * TICK;
  localparam int COAST = 20 * TICK;
  localparam int PER = 8 * TICK;
  localparam int MOVE = 5 * TICK;
  int spin_q;
  int coast_q;
  int pulse_q;
  int pos_q;

  // ==========================================================
  // spindle speed and rotation
  // speed settles only after a while, so the sequencer really has to wait for it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !spindle_enable) spin_q <= 0;
    else if (spin_q < SPIN) spin_q <= spin_q + 1;
  end
  assign speed_out_of_tolerance = (spin_q < SPIN);

  // the disk coasts on after the motor is cut, so pulses outlive spindle_enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) coast_q <= 0;
    else if (spindle_enable) coast_q <= COAST;
    else if (coast_q > 0) coast_q <= coast_q - 1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || coast_q == 0) pulse_q <= 0;
    else pulse_q <= (pulse_q == PER - 1) ? 0 : pulse_q + 1;
  end
  assign rotation_sense_pulse = (coast_q != 0) && (pulse_q == PER - 1);

  // ==========================================================
  // head carriage: takes MOVE cycles to load and as long to retract
  always_ff @(posedge sys_clk) begin
    if (!rst_n) pos_q <= 0;
    else if (head_load_state && pos_q < MOVE) pos_q <= pos_q + 1;
    else if (!head_load_state && pos_q > 0) pos_q <= pos_q - 1;
  end
  assign not_position_mode = !(head_load_state && pos_q >= MOVE);
  assign heads_retracted = !head_load_state && (pos_q == 0);
endmodule // dss_servo_model
